// >>> drss_chk.sv
// Purpose: Watch the link wires between the two ends.
// Assumes: The link is sampled on the system clock.
// Notes: A command is read at the edge after a link clock fall.
`timescale 1ns/1ps
module drss_chk
  import drss_pkg::*;
(
  // Clock, reset and link.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [3:0] ca
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ============================================================
  // Helpers: command taken, gap since all-bank, refresh owed.
  logic ck_q, owe_q, take;
  logic [2:0] pbn_q;  // Per-bank refreshes since exit or all-bank.
  int gap_q;
  assign take = ck_q && !ck && !cs_n;
  always_ff @(posedge i_clk_sys) ck_q <= ck;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) gap_q <= AB_GAP_CYC;
    else if (take && cke && ca[3]) gap_q <= 1;
    else if (gap_q < AB_GAP_CYC) gap_q <= gap_q + 1;
  end
  // Set at each exit; cleared by an all-bank refresh or by the eighth
  // per-bank refresh, since a lone per-bank refresh is not a whole unit.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || $rose(cke)) pbn_q <= 3'h0;
    else if (take && cke) pbn_q <= ca[3] ? 3'h0 : pbn_q + 3'h1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) owe_q <= 1'b0;
    else if ($rose(cke)) owe_q <= 1'b1;
    else if (take && cke && (ca[3] || pbn_q == 3'h7)) owe_q <= 1'b0;
  end
  // ============================================================
  AST_CMD_FALL: assert property (
    !$stable({cke, cs_n, ca}) |-> $fell(ck))
    else $error("Link command moved off a clock fall.");
  AST_REF_CODE: assert property (take |-> ca[2:0] == CA_REFRESH)
    else $error("Selected command is not a refresh code.");
  AST_SR_ENTRY: assert property (
    $fell(cke) |-> !cs_n && ca[2:0] == CA_REFRESH)
    else $error("Clock enable fell without an entry command.");
  AST_TWO_NOP: assert property (
    $fell(cke) |-> ##16 (cs_n && ca == 4'h0) ##16 (cs_n && ca == 4'h0))
    else $error("No-ops missing after entry.");
  AST_HOLD_LOW: assert property ($fell(cke) |=> !cke [*8])
    else $error("Self refresh left too early.");
  AST_STABLE_CLK: assert property (
    $rose(cke) |-> $past(ck) && $past(ck, 17))
    else $error("Exit without two running link clocks.");
  AST_EXIT_NOP: assert property ($rose(cke) |-> (cke && cs_n) [*8]
    ##16 (cke && cs_n) ##16 (cke && cs_n)) else $error("Exit delay broken.");
  AST_AB_GAP: assert property (
    take && cke && ca[3] |-> gap_q >= AB_GAP_CYC)
    else $error("All-bank refreshes too close.");
  AST_REF_AFTER_EXIT: assert property ($fell(cke) |-> !owe_q)
    else $error("Entry again without a refresh.");
endmodule : drss_chk

// >>> drss_ctrl_end.sv
// Purpose: Controller end: refresh scheduling and self-refresh sequencing.
// Assumes: Bank idle and busy inputs come from logic on the same clock.
// Notes: Commands change on link clock falls and are taken on rises.
`timescale 1ns/1ps
module drss_ctrl_end
  import drss_pkg::*;
#(
  parameter int REFRESH_WINDOW_CYC = REFRESH_WINDOW_DEF_CYC,
  parameter int REQ_REFRESHES = REQ_REFRESHES_DEF,
  parameter int PULL_IN = PULL_IN_DEF
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link to the memory die.
  drss_link_if.ctrl link,
  // Bank and operation state from the command scheduler.
  input wire logic [NUM_BANKS-1:0] i_bank_idle,
  input wire logic i_op_busy,
  // Refresh policy.
  input wire logic i_use_pb,
  input wire logic i_burst_mode,
  input wire logic [2:0] i_temp_status,
  // Self-refresh requests.
  input wire logic i_sr_req,
  input wire logic i_sr_exit_req,
  // Status.
  output logic o_in_self_refresh,
  output logic o_ref_issued,
  output logic signed [15:0] o_credit,
  output logic o_rate_alert
);

  localparam int REFI_CYC = REFRESH_WINDOW_CYC / REQ_REFRESHES;
  localparam logic signed [15:0] PULL = 16'(PULL_IN);

  drss_ctl_e state_q;
  logic [3:0] div_cnt_q;  // Divider for the link clock.
  logic ck_q;  // Link clock.
  logic ck_run_q;  // Link clock allowed to rise.
  logic tog, rise_en, fall_en;
  logic cke_q, cs_n_q;
  logic [3:0] ca_q;
  logic [23:0] tick_cnt_q;  // Average refresh interval timer.
  logic tick;
  logic signed [15:0] credit_q;  // Refresh units owed, negative when ahead.
  logic burst_q;  // Burst/pause pattern active.
  logic [7:0] gap_q;  // Spacing to the next refresh.
  logic [2:0] pb_bank_q;  // Mirror of the die's per-bank target.
  logic ref_since_exit_q;  // A refresh unit since the last exit.
  logic [7:0] cnt_q;  // Edge or cycle counter per state.
  logic xsr_on_q;  // Exit delay has started.
  logic all_idle, want_ref, slot, sr_ok;
  logic do_sre, do_ab, do_pb, pb_last, unit_done, wake_go;

  // ============================================================
  // Link clock divider. The clock always finishes a high phase and then
  // parks low, so the die never sees a runt pulse when it stops.
  assign tog = (div_cnt_q == 4'(LINK_HALF - 1));
  assign rise_en = tog && ck_run_q && !ck_q;
  assign fall_en = tog && ck_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_cnt_q <= 4'h0;
      ck_q <= 1'b0;
    end else begin
      div_cnt_q <= tog ? 4'h0 : div_cnt_q + 4'h1;
      if (rise_en) begin
        ck_q <= 1'b1;
      end else if (fall_en) begin
        ck_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // Scheduling decisions, made once per command slot.
  assign all_idle = &i_bank_idle;
  assign pb_last = (pb_bank_q == 3'(NUM_BANKS - 1));
  // Distributed pattern refreshes while owed; a burst runs ahead by up
  // to PULL_IN units, which bounds the pause that follows it.
  assign want_ref = burst_q ? (credit_q > -PULL)
                            : (credit_q > 16'sh0000);
  assign slot = fall_en && (state_q == CT_RUN) && (gap_q == 8'h00);
  // Entry only with banks idle, no data operation, a refresh since the
  // last exit, whole per-bank cycles, and, in the burst pattern, right after a burst.
  assign sr_ok = i_sr_req && all_idle && !i_op_busy
                 && ref_since_exit_q
                 && (pb_bank_q == 3'h0)
                 && (burst_q ? (credit_q == -PULL)
                             : (credit_q <= 16'sh0000));
  assign do_sre = slot && sr_ok;
  assign do_ab = slot && !sr_ok && want_ref && !i_use_pb
                 && all_idle;
  assign do_pb = slot && !sr_ok && want_ref && i_use_pb
                 && i_bank_idle[pb_bank_q];
  assign unit_done = do_ab || (do_pb && pb_last);
  assign wake_go = fall_en && (state_q == CT_WAKE)
                   && (cnt_q >= 8'(STABLE_CLK_CYCLES));

  // ============================================================
  // Interval timer. It stands cleared outside normal running and the exit delay, so time in
  // self refresh owes nothing and a partial interval is forgiven whole.
  assign tick = (tick_cnt_q == 24'(REFI_CYC - 1));

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (state_q != CT_RUN && state_q != CT_XSR)) begin
      tick_cnt_q <= 24'h000000;
    end else if (tick) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end

  // Refresh credit: one unit owed per interval, one paid per all-bank
  // refresh or per complete per-bank cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      credit_q <= 16'sh0000;
    end else begin
      credit_q <= credit_q + (tick ? 16'sh0001 : 16'sh0000)
                  - (unit_done ? 16'sh0001 : 16'sh0000);
    end
  end

  // Pattern choice. Leaving burst mode waits for the end of a burst so
  // no rolling window is left short by a pause.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      burst_q <= 1'b0;
    end else if (i_burst_mode) begin
      burst_q <= 1'b1;
    end else if (credit_q == -PULL && pb_bank_q == 3'h0) begin
      burst_q <= 1'b0;
    end
  end

  // Spacing between refreshes. Four all-bank cycle times between
  // all-bank refreshes keeps any burst window to eight of them.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gap_q <= 8'h00;
    end else if (do_ab) begin
      gap_q <= 8'(AB_GAP_CYC);
    end else if (do_pb) begin
      gap_q <= 8'(PB_CYCLE_CYC);
    end else if (gap_q != 8'h00) begin
      gap_q <= gap_q - 8'h01;
    end
  end

  // Per-bank mirror and the refresh-since-exit flag.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pb_bank_q <= 3'h0;
      ref_since_exit_q <= 1'b1;
    end else if (wake_go) begin
      pb_bank_q <= 3'h0;
      ref_since_exit_q <= 1'b0;
    end else begin
      if (do_ab) begin
        pb_bank_q <= 3'h0;
      end else if (do_pb) begin
        pb_bank_q <= pb_bank_q + 3'h1;
      end
      if (unit_done) begin
        ref_since_exit_q <= 1'b1;
      end
    end
  end

  // ============================================================
  // Command wires, updated on the fall ahead of the taking rise.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cke_q <= 1'b1;
      cs_n_q <= 1'b1;
      ca_q <= 4'h0;
    end else if (fall_en) begin
      cs_n_q <= 1'b1;  // No-op unless a command is chosen.
      ca_q <= 4'h0;
      if (do_sre) begin
        cke_q <= 1'b0;
        cs_n_q <= 1'b0;
        ca_q <= {1'b0, CA_REFRESH};
      end else if (do_ab) begin
        cs_n_q <= 1'b0;
        ca_q <= {1'b1, CA_REFRESH};
      end else if (do_pb) begin
        cs_n_q <= 1'b0;
        ca_q <= {1'b0, CA_REFRESH};
      end else if (wake_go) begin
        cke_q <= 1'b1;
      end
    end
  end

  // ============================================================
  // Self-refresh sequence.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= CT_RUN;
      cnt_q <= 8'h00;
      ck_run_q <= 1'b1;
      xsr_on_q <= 1'b0;
    end else begin
      case (state_q)
        CT_RUN: begin
          if (do_sre) begin
            state_q <= CT_NOP;
            cnt_q <= 8'h00;
          end
        end
        CT_NOP: begin
          // Count the entry rise and the two no-op rises after it.
          if (rise_en) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(CPDED_NOPS)) begin
              state_q <= CT_HOLD;
              ck_run_q <= 1'b0;
              cnt_q <= 8'h00;
            end
          end
        end
        CT_HOLD: begin
          // Clock enable stays low; exit waits for the residency time.
          if (cnt_q != 8'(MIN_SR_RES_CYC)) begin
            cnt_q <= cnt_q + 8'h01;
          end else if (i_sr_exit_req) begin
            state_q <= CT_WAKE;
            ck_run_q <= 1'b1;
            cnt_q <= 8'h00;
          end
        end
        CT_WAKE: begin
          if (wake_go) begin
            state_q <= CT_XSR;
            cnt_q <= 8'h00;
            xsr_on_q <= 1'b0;
          end else if (rise_en) begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        CT_XSR: begin
          // The delay runs from the rise that takes clock enable high;
          // only no-ops go out meanwhile.
          if (!xsr_on_q) begin
            xsr_on_q <= rise_en;
          end else if (cnt_q == 8'(SR_EXIT_CYC - 1)) begin
            state_q <= CT_RUN;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= CT_RUN;
        end
      endcase
    end
  end

  // ============================================================
  // Outputs.
  assign link.ck = ck_q;
  assign link.cke = cke_q;
  assign link.cs_n = cs_n_q;
  assign link.ca = ca_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_in_self_refresh <= 1'b0;
      o_ref_issued <= 1'b0;
      o_credit <= 16'sh0000;
      o_rate_alert <= 1'b0;
    end else begin
      o_in_self_refresh <= (state_q != CT_RUN);
      o_ref_issued <= do_ab || do_pb;
      o_credit <= credit_q;
      // Window figures hold only at the nominal temperature status.
      o_rate_alert <= (i_temp_status != TEMP_NOMINAL);
    end
  end

endmodule : drss_ctrl_end

// >>> drss_dev_end.sv
// Purpose: Memory die end: refresh decode, bank counter, self refresh.
// Assumes: Controller changes command wires while the link clock is low.
// Notes: Link wires are oversampled; only link clock rises are acted on.
`timescale 1ns/1ps
module drss_dev_end
  import drss_pkg::*;
#(
  parameter int REFRESH_WINDOW_CYC = REFRESH_WINDOW_DEF_CYC,
  parameter int REQ_REFRESHES = REQ_REFRESHES_DEF
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link from the controller.
  drss_link_if.dev link,
  // Refresh activity.
  output logic o_ab_refresh,
  output logic o_pb_refresh,
  output logic [2:0] o_pb_bank,
  output logic [NUM_BANKS-1:0] o_bank_busy,
  output logic o_int_refresh,
  // Power state.
  output logic o_self_refresh,
  output logic o_rx_enabled,
  output logic o_clk_gated,
  output logic o_exit_busy
);

  localparam int REFI_CYC = REFRESH_WINDOW_CYC / REQ_REFRESHES;

  logic [6:0] pins_s;  // Synchronised ck, cke, cs_n, ca.
  logic ck_s, cke_s, cs_n_s;
  logic [3:0] ca_s;
  logic ck_d_q;  // Link clock one cycle ago.
  logic rise;  // Link clock rising edge seen.
  logic cke_prev_q;  // Clock enable at the previous link edge.
  logic ref_pat, cmd_ab, cmd_pb, cmd_sre;
  drss_dev_e state_q;
  logic [7:0] cnt_q;  // Edge or cycle counter per state.
  logic [23:0] sr_tmr_q;  // Internal refresh timer.
  logic [2:0] bank_q;  // Next per-bank target.
  logic [2:0] pb_tgt_q;  // Bank under per-bank refresh.
  logic [7:0] ab_tmr_q, pb_tmr_q;  // Busy timers.

  // ============================================================
  // Sampling of the link
  drss_sync #(.W(7)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d({link.ck, link.cke, link.cs_n, link.ca}),
    .o_q(pins_s)
  );
  assign {ck_s, cke_s, cs_n_s, ca_s} = pins_s;
  assign rise = ck_s && !ck_d_q;

  // Edge detector and clock enable history; a stopped clock simply
  // produces no edges, so nothing here needs it to run free.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ck_d_q <= 1'b0;
      cke_prev_q <= 1'b1;
    end else begin
      ck_d_q <= ck_s;
      if (rise) begin
        cke_prev_q <= cke_s;
      end
    end
  end

  // ============================================================
  // Command decode
  assign ref_pat = !cs_n_s && (ca_s[2:0] == CA_REFRESH);
  assign cmd_ab = rise && cke_s && cke_prev_q && ref_pat && ca_s[3]
                  && (state_q == DV_ACTIVE);
  assign cmd_pb = rise && cke_s && cke_prev_q && ref_pat && !ca_s[3]
                  && (state_q == DV_ACTIVE);
  // Entry needs a falling clock enable; re-entry is allowed in exit.
  assign cmd_sre = rise && !cke_s && cke_prev_q && ref_pat
                   && ((state_q == DV_ACTIVE) || (state_q == DV_EXIT));

  // ============================================================
  // Power state machine.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= DV_ACTIVE;
      cnt_q <= 8'h00;
    end else begin
      case (state_q)
        DV_ACTIVE: begin
          if (cmd_sre) begin
            state_q <= DV_ENTRY;
            cnt_q <= 8'h00;
          end
        end
        DV_ENTRY: begin
          // Receivers stay on for the two no-op edges.
          if (rise) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(CPDED_NOPS - 1)) begin
              state_q <= DV_SELF;
            end
          end
        end
        DV_SELF: begin
          // Only clock enable is looked at here.
          if (rise && cke_s) begin
            state_q <= DV_EXIT;
            cnt_q <= 8'h00;
          end
        end
        DV_EXIT: begin
          if (cmd_sre) begin
            state_q <= DV_ENTRY;
            cnt_q <= 8'h00;
          end else if (cnt_q == 8'(SR_EXIT_CYC - 1)) begin
            state_q <= DV_ACTIVE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= DV_ACTIVE;
        end
      endcase
    end
  end

  // Internal refresh timer on the system clock: the first refresh fires on
  // entering self refresh, well inside the residency time.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (state_q != DV_SELF)) begin
      sr_tmr_q <= 24'h000000;
    end else if (sr_tmr_q == 24'(REFI_CYC - 1)) begin
      sr_tmr_q <= 24'h000000;
    end else begin
      sr_tmr_q <= sr_tmr_q + 24'h000001;
    end
  end

  // ============================================================
  // Per-bank target counter and busy timers.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bank_q <= 3'h0;
      pb_tgt_q <= 3'h0;
      ab_tmr_q <= 8'h00;
      pb_tmr_q <= 8'h00;
    end else begin
      if (cmd_ab || (state_q == DV_SELF && rise && cke_s)) begin
        bank_q <= 3'h0;
      end else if (cmd_pb) begin
        bank_q <= bank_q + 3'h1;
      end
      if (cmd_ab) begin
        ab_tmr_q <= 8'(AB_CYCLE_CYC);
      end else if (ab_tmr_q != 8'h00) begin
        ab_tmr_q <= ab_tmr_q - 8'h01;
      end
      if (cmd_pb) begin
        pb_tgt_q <= bank_q;
        pb_tmr_q <= 8'(PB_CYCLE_CYC);
      end else if (pb_tmr_q != 8'h00) begin
        pb_tmr_q <= pb_tmr_q - 8'h01;
      end
    end
  end

  // ============================================================
  // Registered outputs; a per-bank refresh marks its target only.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ab_refresh <= 1'b0;
      o_pb_refresh <= 1'b0;
      o_pb_bank <= 3'h0;
      o_bank_busy <= '0;
      o_int_refresh <= 1'b0;
      o_self_refresh <= 1'b0;
      o_rx_enabled <= 1'b1;
      o_clk_gated <= 1'b0;
      o_exit_busy <= 1'b0;
    end else begin
      o_ab_refresh <= cmd_ab;
      o_pb_refresh <= cmd_pb;
      o_pb_bank <= bank_q;
      if (ab_tmr_q != 8'h00) begin
        o_bank_busy <= '1;
      end else if (pb_tmr_q != 8'h00) begin
        o_bank_busy <= NUM_BANKS'(1) << pb_tgt_q;
      end else begin
        o_bank_busy <= '0;
      end
      o_int_refresh <= (state_q == DV_SELF)
                       && (sr_tmr_q == 24'h000000);
      o_self_refresh <= (state_q == DV_SELF);
      o_rx_enabled <= (state_q != DV_SELF);
      o_clk_gated <= (state_q == DV_SELF);
      o_exit_busy <= (state_q == DV_EXIT);
    end
  end

endmodule : drss_dev_end

// >>> drss_link_if.sv
// Purpose: Command and clock wires between controller and memory die.
// Assumes: The controller drives every wire; the die only listens.
// Notes: No clocking block; the die samples through synchronisers.
`timescale 1ns/1ps
interface drss_link_if;
  logic ck;  // Link clock made by the controller.
  logic cke;  // Clock enable, high when active.
  logic cs_n;  // Chip select, active low.
  logic [3:0] ca;  // Command bits CA3 to CA0.
  modport ctrl (output ck, output cke, output cs_n, output ca);
  modport dev (input ck, input cke, input cs_n, input ca);
endinterface : drss_link_if

// >>> drss_pkg.sv
// Purpose: Shared constants and types for the refresh and self-refresh link.
// Assumes: One system clock at 250 MHz drives both ends.
// Notes: Times are kept in their own unit and turned into cycle counts here.
// ============================================================
// Notes on behaviour
// - Refresh only banks that are idle.
// - Meet required refresh count every rolling window.
// - Eight per-bank refreshes replace one all-bank.
// - At most eight all-bank refreshes per burst window.
// - Self-refresh time reduces required count, rounded up.
// - Regular scheme: one refresh per average interval.
// - Burst then pause, pause length bounded.
// - Switch to distributed only right after burst.
// - Self refresh counts as distributed; enter after burst.
// - Other banks stay usable during per-bank refresh.
// - Self-refresh entry decode needs prior clock-enable high.
// - Never drop clock enable during data operations.
// - Two no-ops after entry, then receivers off.
// - Clock enable low holds self refresh; rest ignored.
// - Own timer refreshes; link clock gated off.
// - Internal refresh within residency; hold residency time.
// - Clock may stop after entry; restart before exit.
// - Two stable clocks before clock enable rises.
// - Exit delay: clock enable high, no-ops only.
// - One refresh unit between exit and next entry.
// - All banks idle before self-refresh entry.
// - Refresh decode; CA3 picks all-bank or per-bank.
// - Per-bank target counter round-robin, resets on sync.
package drss_pkg;

  // ============================================================
  // Clock and time conversion
  localparam int CLK_NS = 4;  // System clock period in ns.

  // Least time to cycles, rounded up.
  function automatic int drss_cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction : drss_cyc_up

  // ============================================================
  // Refresh timing
  localparam int REFRESH_WINDOW_MS = 32;  // Window at nominal temperature.
  localparam int REFRESH_WINDOW_DEF_CYC = REFRESH_WINDOW_MS * 1000000 / CLK_NS;
  localparam int REQ_REFRESHES_DEF = 8192;  // Required count per window.
  localparam int PULL_IN_DEF = 8;  // Refreshes a burst may run ahead.
  localparam int AB_CYCLE_NS = 130;  // All-bank refresh cycle time.
  localparam int AB_CYCLE_CYC = drss_cyc_up(AB_CYCLE_NS);
  localparam int PB_CYCLE_NS = 60;  // Single-bank refresh cycle time.
  localparam int PB_CYCLE_CYC = drss_cyc_up(PB_CYCLE_NS);
  localparam int BURST_MAX_AB = 8;  // All-bank refreshes per burst window.
  localparam int BURST_WINDOW_CYC = 4 * BURST_MAX_AB * AB_CYCLE_CYC;
  localparam int AB_GAP_CYC = BURST_WINDOW_CYC / BURST_MAX_AB;

  // ============================================================
  // Self-refresh timing
  localparam int MIN_SR_RES_NS = 15;  // Minimum self-refresh residency.
  localparam int MIN_SR_RES_CYC = drss_cyc_up(MIN_SR_RES_NS);
  localparam int SR_EXIT_NS = 140;  // Self-refresh exit delay.
  localparam int SR_EXIT_CYC = drss_cyc_up(SR_EXIT_NS);
  localparam int CPDED_NOPS = 2;  // No-ops inside the clock-enable delay.
  localparam int STABLE_CLK_CYCLES = 2;  // Stable clocks before exit.

  // ============================================================
  // Link clock and encodings
  localparam int LINK_PERIOD_NS = 64;
  localparam int LINK_HALF = LINK_PERIOD_NS / 2 / CLK_NS;  // In sys cycles.
  localparam int NUM_BANKS = 8;
  localparam logic [2:0] CA_REFRESH = 3'h4;  // CA2 high, CA1 and CA0 low.
  localparam logic [2:0] TEMP_NOMINAL = 3'h3;  // Status for the 32 ms window.

  // Controller end states.
  typedef enum logic [2:0] {
    CT_RUN = 3'b000,
    CT_NOP = 3'b001,
    CT_HOLD = 3'b010,
    CT_WAKE = 3'b011,
    CT_XSR = 3'b100
  } drss_ctl_e;

  // Device end states.
  typedef enum logic [1:0] {
    DV_ACTIVE = 2'b00,
    DV_ENTRY = 2'b01,
    DV_SELF = 2'b10,
    DV_EXIT = 2'b11
  } drss_dev_e;

endpackage : drss_pkg

// >>> drss_sync.sv
// Purpose: Two-flop synchroniser for a group of link inputs.
// Assumes: Each bit is a level; bits may skew by one cycle.
// Notes: The first stage feeds the second stage only.
`timescale 1ns/1ps
module drss_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Asynchronous data in, synchronised data out.
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;  // First stage, read by the second only.

  // ============================================================
  // Two stages; metastability settles in the first.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule : drss_sync

// >>> tb_dram_refresh_self_refresh.sv
// Purpose: Bench for both link ends under each burst and per-bank policy in turn.
// Assumes: A short window keeps the run brief.
// Notes: The monitor tracks the expected per-bank target.
`timescale 1ns/1ps
module tb_dram_refresh_self_refresh;
  import drss_pkg::*;
  logic i_clk_sys = 0, i_rst = 1, op_busy = 0, use_pb = 0, burst = 0;
  logic sr_req = 0, sr_exit = 0, in_sr, ref_iss, rate, ab, pb, intr;
  logic self, rx, gated, exitb, ab_q = 0, pb_q = 0;
  logic [7:0] idle = 8'hff, busy;
  logic [2:0] temp = 3'h3, pbb, e = 3'h0;
  logic signed [15:0] credit;
  int n_mismatch = 0, comparisons = 0, n_iss = 0, n_dec = 0, n_int = 0, k;
  always #2 i_clk_sys = ~i_clk_sys;
  drss_link_if drss_link_if_inst();
  // The interval must exceed a whole refresh unit so the credit can fall.
  drss_ctrl_end #(.REFRESH_WINDOW_CYC(16384), .REQ_REFRESHES(64))
    drss_ctrl_end_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(drss_link_if_inst),
    .i_bank_idle(idle), .i_op_busy(op_busy), .i_use_pb(use_pb),
    .i_burst_mode(burst), .i_temp_status(temp), .i_sr_req(sr_req),
    .i_sr_exit_req(sr_exit), .o_in_self_refresh(in_sr),
    .o_ref_issued(ref_iss), .o_credit(credit), .o_rate_alert(rate));
  drss_dev_end #(.REFRESH_WINDOW_CYC(16384), .REQ_REFRESHES(64))
    drss_dev_end_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(drss_link_if_inst),
    .o_ab_refresh(ab), .o_pb_refresh(pb), .o_pb_bank(pbb),
    .o_bank_busy(busy), .o_int_refresh(intr), .o_self_refresh(self),
    .o_rx_enabled(rx), .o_clk_gated(gated), .o_exit_busy(exitb));
  drss_chk drss_chk_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .ck(drss_link_if_inst.ck), .cke(drss_link_if_inst.cke),
    .cs_n(drss_link_if_inst.cs_n), .ca(drss_link_if_inst.ca));
  task automatic chk(input string nm, input logic [15:0] ex, sn);
    comparisons++;
    if (ex !== sn) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  function automatic logic [15:0] bank_mask(input logic [2:0] b);
    return 16'(8'h01 << b);
  endfunction : bank_mask
  // Monitor: every taken refresh must match one issued by the controller.
  always @(posedge i_clk_sys) if (!i_rst) begin
    n_iss <= n_iss + ref_iss;
    n_int <= n_int + intr;
    ab_q <= ab;
    pb_q <= pb;
    if (ab | pb) n_dec <= n_dec + 1;
    if (ab | pb) chk("issued", 16'(n_iss + ref_iss), 16'(n_dec + 1));
    if (pb) chk("pb bank", 16'(e), 16'(pbb));
    // Busy marks follow the refresh pulse by one cycle.
    if (pb_q) chk("pb busy", bank_mask(e - 3'h1), 16'(busy));
    if (ab_q) chk("ab busy", 16'hff, 16'(busy));
    if (self) chk("gated", 16'h1, 16'({rx, gated}));
    if (exitb) chk("bank count", 16'h0, 16'(pbb));
    if (intr) chk("int in self", 16'h1, 16'(self));
    if (ab | exitb) e <= 3'h0;
    else if (pb) e <= e + 3'h1;
  end
  initial begin
    k = $urandom(32'he4ada87c);
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 0;
    for (int m = 0; m < 12; m++) begin
      @(posedge i_clk_sys);
      {burst, use_pb} <= 2'(m);
      temp <= (m % 3 == 0) ? 3'h3 : 3'($urandom);
      op_busy <= 1'($urandom);
      idle <= ($urandom % 4 == 0) ? 8'($urandom) : 8'hff;
      repeat (4) @(posedge i_clk_sys);
      chk("rate alert", 16'(temp !== TEMP_NOMINAL), 16'(rate));
      repeat (600) @(posedge i_clk_sys);
    end
    idle <= 8'hff;
    op_busy <= 0;
    temp <= 3'h3;
    for (int s = 0; s < 2; s++) begin
      sr_req <= 1;
      for (k = 0; k < 6000 && self !== 1; k++) @(posedge i_clk_sys);
      repeat (20) @(posedge i_clk_sys);
      chk("sr entry", 16'h1, 16'(self));
      chk("credit", 16'(-PULL_IN_DEF), 16'(credit));
      chk("rx off", 16'h0, 16'(rx));
      sr_req <= 0;
      sr_exit <= 1;
      for (k = 0; k < 2000 && in_sr !== 0; k++) @(posedge i_clk_sys);
      sr_exit <= 0;
      chk("sr exit", 16'h0, 16'(in_sr));
      chk("int refresh", 16'h1, 16'(n_int > 0));
      chk("rx back", 16'h1, 16'(rx));
    end
    conclude();
  end
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    n_mismatch++;
    conclude();
  end
endmodule : tb_dram_refresh_self_refresh
